// ==== bgrb_defs.svh ====
// register offsets, field positions and reset values of the board glue register bank
`ifndef BGRB_DEFS_SVH
`define BGRB_DEFS_SVH

`define BGRB_OFF_IRQEN 32'h0900_0000
`define BGRB_OFF_IRQSTAT 32'h0900_0004
`define BGRB_OFF_CLKCFG 32'h0900_0008
`define BGRB_OFF_ROUTE 32'h0900_000c
`define BGRB_OFF_VERSION 32'h0900_0010
`define BGRB_OFF_DISPLAY 32'h0900_0014
`define BGRB_OFF_LEDS 32'h0900_0018

`define BGRB_CFG_REQ_BIT 0
`define BGRB_CFG_STATE_BIT 1
`define BGRB_CFG_M66_BIT 2

`define BGRB_ROUTE_PCI_LSB 0
`define BGRB_ROUTE_FIRST_LSB 2
`define BGRB_ROUTE_SECOND_LSB 4

`define BGRB_RST_CLKCFG 32'h0000_0004
`define BGRB_RST_ROUTE 32'h0000_0039
`define BGRB_RST_IRQEN 32'h0000_0000
`define BGRB_RST_DISPLAY 32'h0000_0000
`define BGRB_RST_LEDS 32'h0000_0000

// idle levels of the pin synchronisers: pci and buttons high, jumper out, m66en high
`define BGRB_SYNC_RST 8'hfd

`endif

// ==== bgrb_pkg.sv ====
// types of the board glue register bank
package bgrb_pkg;

   typedef enum logic [1:0] {
      BGRB_LINE_ONE = 2'h0,
      BGRB_LINE_THREE = 2'h1,
      BGRB_LINE_FOUR = 2'h2,
      BGRB_LINE_SEVEN = 2'h3
   } bgrb_line_t;

   typedef struct packed {
      logic [7:0] pin_meta;
      logic [7:0] pin_sync;
      logic [5:0] irqen;
      logic [5:0] route;
      logic req;
      logic [7:0] disp;
      logic [1:0] leds;
      logic gen_out;
      logic [3:0] lines;
      logic [6:0] seg_lo;
      logic [6:0] seg_hi;
      logic [31:0] rdata;
      logic ack;
   } bgrb_state_t;

endpackage : bgrb_pkg

// ==== bgrb_register_bank.sv ====
// register bank: pci clock speed, interrupt routing, version, display and leds
`timescale 1ns/1ns
`include "bgrb_defs.svh"

// Functional notes
// - clock config bit 2 shows the live synchronised m66en level
// - clock config bit 1 reports the present speed select output
// - speed select asserts only with m66en high, jumper out, request set
// - clock config bit 0 is the speed request, ignored while m66en low
// - a fitted speed jumper forces 33 MHz, speed select stays low
// - routing bits 5-4 steer second pushbutton to lines 1, 3, 4 or 7
// - routing bits 3-2 steer first pushbutton, bits 1-0 the pci interrupts
// - version word is read only: week, zero byte, major, minor
// - display low byte is shown as two hex digits on the segments
// - led register bit 1 drives second led, bit 0 the first
// - a source reaches its routed line only while its enable bit is set
// - reset values: clock config 0x4, routing 0x39, display and leds zero
module bgrb_register_bank
   import bgrb_pkg::*;
#(
   parameter logic [7:0] BUILD_WORK_WEEK = 8'h10, // arbitrary value
   parameter logic [7:0] MAJOR_REVISION = 8'h00, // arbitrary value
   parameter logic [7:0] MINOR_REVISION = 8'h01 // arbitrary value
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic bus_sel,
   input wire logic bus_write,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   output logic [31:0] bus_rdata,
   output logic bus_ack,
   input wire logic pci_m66en,
   input wire logic speed_jumper_header,
   input wire logic first_pushbutton_n,
   input wire logic second_pushbutton_n,
   input wire logic [3:0] pci_slot_irq_n,
   output logic generator_speed_input,
   output logic host_interrupt_line_one,
   output logic host_interrupt_line_three,
   output logic host_interrupt_line_four,
   output logic host_interrupt_line_seven,
   output logic [6:0] segment_low_digit,
   output logic [6:0] segment_high_digit,
   output logic first_indicator_output,
   output logic second_indicator_output
);

   localparam logic [31:0] VERSION_WORD =
      {BUILD_WORK_WEEK, 8'h00, MAJOR_REVISION, MINOR_REVISION};

   bgrb_state_t st_reg;
   bgrb_state_t st_next;

   logic m66_live;
   logic jumper_fitted;
   logic first_button_active;
   logic second_button_active;
   logic [3:0] pci_active;
   logic [5:0] status_word;
   logic wr_strobe;
   logic rd_strobe;

   // one-hot line vector {seven, four, three, one} for a routed source
   function automatic logic [3:0] bgrb_line_of(input logic [1:0] sel, input logic active);
      logic [3:0] hot;
      hot = 4'h0;
      unique case (bgrb_line_t'(sel))
         BGRB_LINE_ONE: hot = 4'h1;
         BGRB_LINE_THREE: hot = 4'h2;
         BGRB_LINE_FOUR: hot = 4'h4;
         BGRB_LINE_SEVEN: hot = 4'h8;
      endcase
      return active ? hot : 4'h0;
   endfunction : bgrb_line_of

   // hex digit to segments gfedcba, active high
   function automatic logic [6:0] bgrb_hex7(input logic [3:0] nib);
      logic [6:0] seg;
      seg = 7'h00;
      unique case (nib)
         4'h0: seg = 7'h3f;
         4'h1: seg = 7'h06;
         4'h2: seg = 7'h5b;
         4'h3: seg = 7'h4f;
         4'h4: seg = 7'h66;
         4'h5: seg = 7'h6d;
         4'h6: seg = 7'h7d;
         4'h7: seg = 7'h07;
         4'h8: seg = 7'h7f;
         4'h9: seg = 7'h6f;
         4'ha: seg = 7'h77;
         4'hb: seg = 7'h7c;
         4'hc: seg = 7'h39;
         4'hd: seg = 7'h5e;
         4'he: seg = 7'h79;
         4'hf: seg = 7'h71;
      endcase
      return seg;
   endfunction : bgrb_hex7

   // synchronised pin levels, read only from the second stage
   assign m66_live = st_reg.pin_sync[0];
   assign jumper_fitted = st_reg.pin_sync[1];
   assign first_button_active = ~st_reg.pin_sync[2];
   assign second_button_active = ~st_reg.pin_sync[3];
   assign pci_active = ~st_reg.pin_sync[7:4];
   assign status_word = {second_button_active, first_button_active, pci_active};

   // every access is a full word, so no byte lanes are decoded
   assign wr_strobe = bus_sel & bus_write;
   assign rd_strobe = bus_sel & ~bus_write;

   always_comb begin
      st_next = st_reg;
      st_next.pin_meta = {pci_slot_irq_n, second_pushbutton_n, first_pushbutton_n,
         speed_jumper_header, pci_m66en};
      st_next.pin_sync = st_reg.pin_meta;
      st_next.ack = bus_sel;

      // register writes, reserved bits dropped
      if (wr_strobe) begin
         unique case (bus_addr)
            `BGRB_OFF_IRQEN: begin
               st_next.irqen = bus_wdata[5:0];
            end
            `BGRB_OFF_CLKCFG: begin
               st_next.req = bus_wdata[`BGRB_CFG_REQ_BIT];
            end
            `BGRB_OFF_ROUTE: begin
               st_next.route = bus_wdata[5:0];
            end
            `BGRB_OFF_DISPLAY: begin
               st_next.disp = bus_wdata[7:0];
            end
            `BGRB_OFF_LEDS: begin
               st_next.leds = bus_wdata[1:0];
            end
            default: begin
            end
         endcase
      end

      // speed select: jumper and m66en override the request
      st_next.gen_out = m66_live & ~jumper_fitted & st_reg.req;

      // routing of enabled sources onto the host lines
      st_next.lines =
         bgrb_line_of(st_reg.route[`BGRB_ROUTE_SECOND_LSB +: 2],
            second_button_active & st_reg.irqen[5]) |
         bgrb_line_of(st_reg.route[`BGRB_ROUTE_FIRST_LSB +: 2],
            first_button_active & st_reg.irqen[4]) |
         bgrb_line_of(st_reg.route[`BGRB_ROUTE_PCI_LSB +: 2],
            |(pci_active & st_reg.irqen[3:0]));

      // segments follow the display value as it is stored
      st_next.seg_lo = bgrb_hex7(st_next.disp[3:0]);
      st_next.seg_hi = bgrb_hex7(st_next.disp[7:4]);

      // read data, unmapped and reserved positions read zero
      st_next.rdata = 32'h0000_0000;
      if (rd_strobe) begin
         unique case (bus_addr)
            `BGRB_OFF_IRQEN: begin
               st_next.rdata = {26'h0, st_reg.irqen};
            end
            `BGRB_OFF_IRQSTAT: begin
               st_next.rdata = {26'h0, status_word};
            end
            `BGRB_OFF_CLKCFG: begin
               st_next.rdata = {29'h0, m66_live, st_reg.gen_out, st_reg.req};
            end
            `BGRB_OFF_ROUTE: begin
               st_next.rdata = {26'h0, st_reg.route};
            end
            `BGRB_OFF_VERSION: begin
               st_next.rdata = VERSION_WORD;
            end
            `BGRB_OFF_DISPLAY: begin
               st_next.rdata = {24'h0, st_reg.disp};
            end
            `BGRB_OFF_LEDS: begin
               st_next.rdata = {30'h0, st_reg.leds};
            end
            default: begin
               st_next.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_reg.pin_meta <= `BGRB_SYNC_RST;
         st_reg.pin_sync <= `BGRB_SYNC_RST;
         st_reg.irqen <= 6'(`BGRB_RST_IRQEN);
         st_reg.route <= 6'(`BGRB_RST_ROUTE);
         st_reg.req <= 1'b0;
         st_reg.disp <= 8'(`BGRB_RST_DISPLAY);
         st_reg.leds <= 2'(`BGRB_RST_LEDS);
         st_reg.gen_out <= 1'b0;
         st_reg.lines <= 4'h0;
         st_reg.seg_lo <= 7'h3f;
         st_reg.seg_hi <= 7'h3f;
         st_reg.rdata <= 32'h0000_0000;
         st_reg.ack <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus_rdata = st_reg.rdata;
   assign bus_ack = st_reg.ack;
   assign generator_speed_input = st_reg.gen_out;
   assign host_interrupt_line_one = st_reg.lines[0];
   assign host_interrupt_line_three = st_reg.lines[1];
   assign host_interrupt_line_four = st_reg.lines[2];
   assign host_interrupt_line_seven = st_reg.lines[3];
   assign segment_low_digit = st_reg.seg_lo;
   assign segment_high_digit = st_reg.seg_hi;
   assign first_indicator_output = st_reg.leds[0];
   assign second_indicator_output = st_reg.leds[1];

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_cfg_read;
      rd_strobe && bus_addr == `BGRB_OFF_CLKCFG;
   endsequence

   sequence s_ver_read;
      rd_strobe && bus_addr == `BGRB_OFF_VERSION;
   endsequence

   sequence s_led_write;
      wr_strobe && bus_addr == `BGRB_OFF_LEDS;
   endsequence

   sequence s_second_to_seven;
      second_button_active && st_reg.irqen[5] && st_reg.route[5:4] == 2'h3;
   endsequence

   a_m66_report: assert property (s_cfg_read |=> bus_rdata[2] == $past(m66_live))
      else $error("m66en level not reported");

   a_state_report: assert property (
      s_cfg_read |=> bus_rdata[1] == $past(generator_speed_input))
      else $error("speed state not reported");

   a_speed_gate: assert property (
      generator_speed_input |-> $past(m66_live && !jumper_fitted && st_reg.req))
      else $error("speed select without all conditions");

   a_m66_low_ignores: assert property (!m66_live |=> !generator_speed_input)
      else $error("request honoured with m66en low");

   a_jumper_forces: assert property (
      jumper_fitted |=> !generator_speed_input)
      else $error("jumper did not force 33 MHz");

   a_second_route: assert property (s_second_to_seven |=> host_interrupt_line_seven)
      else $error("second pushbutton not on line seven");

   a_version_ro: assert property (
      s_ver_read |=> bus_rdata == VERSION_WORD && bus_rdata[23:16] == 8'h00)
      else $error("version word wrong");

   a_led_drive: assert property (
      s_led_write |=> first_indicator_output == $past(bus_wdata[0])
         && second_indicator_output == $past(bus_wdata[1]))
      else $error("leds do not follow write");

   a_disabled_quiet: assert property (
      st_reg.irqen == 6'h00 |=> st_reg.lines == 4'h0)
      else $error("disabled source reached a line");

   a_reserved_zero: assert property (s_cfg_read |=> bus_rdata[31:3] == 29'h0)
      else $error("reserved bits not zero");

   a_display_digit: assert property (
      wr_strobe && bus_addr == `BGRB_OFF_DISPLAY |=>
         segment_low_digit == bgrb_hex7($past(bus_wdata[3:0])))
      else $error("display digit wrong");

endmodule : bgrb_register_bank

// ==== bgrb_host_model.sv ====
// host bus model: single full-word accesses on the register bus
`timescale 1ns/1ns
module bgrb_host_model (
   input wire logic clock,
   output logic bus_sel,
   output logic bus_write,
   output logic [31:0] bus_addr,
   output logic [31:0] bus_wdata,
   input wire logic [31:0] bus_rdata,
   input wire logic bus_ack
);
   initial begin
      bus_sel = 1'b0;
      bus_write = 1'b0;
      bus_addr = 32'h0;
      bus_wdata = 32'h0;
   end

   // one select cycle; reply taken while ack stands, then select dropped and address and data driven inverted
   task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ack);
      @(negedge clock);
      bus_sel = 1'b1;
      bus_write = wr;
      bus_addr = a;
      bus_wdata = d;
      @(negedge clock);
      q = bus_rdata;
      ack = bus_ack;
      bus_sel = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask : access
endmodule : bgrb_host_model

// ==== bgrb_register_bank_test.sv ====
// self-checking testbench of the board glue register bank
`timescale 1ns/1ns
`include "bgrb_defs.svh"
module bgrb_register_bank_test;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic bus_sel, bus_write, bus_ack;
   logic [31:0] bus_addr, bus_wdata, bus_rdata, q, d;
   logic pci_m66en = 1'b1;
   logic speed_jumper_header = 1'b0;
   logic first_pushbutton_n = 1'b1;
   logic second_pushbutton_n = 1'b1;
   logic [3:0] pci_slot_irq_n = 4'hf;
   logic generator_speed_input, first_indicator_output, second_indicator_output, ack;
   logic host_interrupt_line_one, host_interrupt_line_three;
   logic host_interrupt_line_four, host_interrupt_line_seven;
   logic [6:0] segment_low_digit, segment_high_digit;
   logic [3:0] lines;
   logic [5:0] route;
   logic [31:0] lfsr = 32'h25;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [6:0] segs [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
      7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};

   assign lines = {host_interrupt_line_seven, host_interrupt_line_four,
      host_interrupt_line_three, host_interrupt_line_one};

   always #10 clock = ~clock;

   bgrb_register_bank #(.BUILD_WORK_WEEK(8'h2a), .MAJOR_REVISION(8'h03),
      .MINOR_REVISION(8'h07)) bgrb_register_bank_i (.clock, .rst, .bus_sel, .bus_write,
      .bus_addr, .bus_wdata, .bus_rdata, .bus_ack, .pci_m66en, .speed_jumper_header,
      .first_pushbutton_n, .second_pushbutton_n, .pci_slot_irq_n, .generator_speed_input,
      .host_interrupt_line_one, .host_interrupt_line_three, .host_interrupt_line_four,
      .host_interrupt_line_seven, .segment_low_digit, .segment_high_digit,
      .first_indicator_output, .second_indicator_output);

   bgrb_host_model bgrb_host_model_i (.clock, .bus_sel, .bus_write, .bus_addr, .bus_wdata,
      .bus_rdata, .bus_ack);

   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next_rand

   function automatic logic speed(input logic m, input logic j, input logic r);
      return m & ~j & r;
   endfunction : speed

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      bgrb_host_model_i.access(1'b1, a, v, q, ack);
      check({31'h0, ack}, 32'h1);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      bgrb_host_model_i.access(1'b0, a, 32'h0, q, ack);
      check({31'h0, ack}, 32'h1);
      check(q, exp);
   endtask : rd

   task automatic settle;
      repeat (4) @(negedge clock);
   endtask : settle

   task automatic reset_values;
      rd(`BGRB_OFF_CLKCFG, `BGRB_RST_CLKCFG);
      rd(`BGRB_OFF_ROUTE, `BGRB_RST_ROUTE);
      rd(`BGRB_OFF_DISPLAY, `BGRB_RST_DISPLAY);
      rd(`BGRB_OFF_LEDS, `BGRB_RST_LEDS);
      check({18'h0, segment_high_digit, segment_low_digit}, {18'h0, segs[0], segs[0]});
      check({30'h0, second_indicator_output, first_indicator_output}, 32'h0);
      check({31'h0, generator_speed_input}, 32'h0);
   endtask : reset_values

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         test_done;
      end
   end

   initial begin
      repeat (3) @(negedge clock);
      rst = 1'b0;
      reset_values;
      wr(`BGRB_OFF_VERSION, 32'hffff_ffff);
      rd(`BGRB_OFF_VERSION, 32'h2a00_0307);
      rd(32'h0900_001c, 32'h0);
      // every pin and request combination of the speed select
      for (int i = 0; i < 8; i++) begin
         pci_m66en = i[2];
         speed_jumper_header = i[1];
         wr(`BGRB_OFF_CLKCFG, {31'h7fff_fffc, i[0]});
         settle;
         rd(`BGRB_OFF_CLKCFG, {29'h0, i[2], speed(i[2], i[1], i[0]), i[0]});
         check({31'h0, generator_speed_input}, {31'h0, speed(i[2], i[1], i[0])});
      end
      // each source to each line, other fields random, then masked
      for (int s = 0; s < 3; s++) begin
         for (int c = 0; c < 4; c++) begin
            lfsr = next_rand(lfsr);
            route = lfsr[5:0];
            route[2 * s +: 2] = c[1:0];
            wr(`BGRB_OFF_ROUTE, {lfsr[31:6], route});
            rd(`BGRB_OFF_ROUTE, {26'h0, route});
            d = (s == 0) ? (32'h1 << lfsr[7:6]) : (32'h1 << (s + 3));
            wr(`BGRB_OFF_IRQEN, d);
            rd(`BGRB_OFF_IRQEN, d);
            pci_slot_irq_n = (s == 0) ? ~(4'h1 << lfsr[7:6]) : 4'hf;
            first_pushbutton_n = (s != 1);
            second_pushbutton_n = (s != 2);
            settle;
            check({28'h0, lines}, 32'h1 << c);
            wr(`BGRB_OFF_IRQEN, 32'h0);
            settle;
            check({28'h0, lines}, 32'h0);
            rd(`BGRB_OFF_IRQSTAT, d);
            pci_slot_irq_n = 4'hf;
            first_pushbutton_n = 1'b1;
            second_pushbutton_n = 1'b1;
         end
      end
      for (int k = 0; k < 6; k++) begin
         lfsr = next_rand(lfsr);
         d = (k == 0) ? 32'hffff_ffff : lfsr;
         wr(`BGRB_OFF_DISPLAY, d);
         rd(`BGRB_OFF_DISPLAY, {24'h0, d[7:0]});
         check({18'h0, segment_high_digit, segment_low_digit},
            {18'h0, segs[d[7:4]], segs[d[3:0]]});
      end
      for (int k = 0; k < 4; k++) begin
         wr(`BGRB_OFF_LEDS, {30'h3fff_ffff, k[1:0]});
         rd(`BGRB_OFF_LEDS, {30'h0, k[1:0]});
         check({30'h0, second_indicator_output, first_indicator_output}, {30'h0, k[1:0]});
      end
      // reset in mid-run brings every written register back
      rst = 1'b1;
      @(negedge clock);
      rst = 1'b0;
      reset_values;
      test_done;
   end
endmodule : bgrb_register_bank_test
